// ---- bench/cfs_host.sv ----
// Purpose: Host model issuing register strobes
// Assumes: Strobes change at the falling edge only
// Notes: One single-byte request per call
module cfs_host
  import cfs_pkg::*;
(
  input wire logic clk_i,
  output cfs_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Strobe lasts one cycle; idle gap avoids double drive
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_i);
    req_o = '0;
  endtask
endmodule // cfs_host

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the fault and status registers
// Assumes: Default identity parameters
// Notes: Conditions settle through two flops before each read
module tb_top
  import cfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, vp, cp, rp, tp;
  cfs_cond_t cond;
  cfs_req_t req;
  logic [7:0] rdata, a, d;
  logic [1:0] mask;
  logic [31:0] r;
  logic [7:0] adr [4] = '{8'h09, 8'h0a, 8'h0b, 8'h0c};
  int bad_count, n_tests, seed, vcnt, ccnt;

  cfs_regs cfs_regs_inst (.clk_i(clk), .sys_rst_i(sys_rst), .cond_i(cond),
    .req_i(req), .reg_rdata_o(rdata), .voltage_reg_irq_pulse_o(vp),
    .current_reg_irq_pulse_o(cp), .reg_reset_pulse_o(rp),
    .safety_timer_restart_o(tp));
  cfs_host cfs_host_inst (.clk_i(clk), .req_o(req));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (vp) vcnt++;
    if (cp) ccnt++;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Priority thermal over timer over input
  function automatic logic [7:0] model(input logic [7:0] ad);
    logic [1:0] c;
    c = cond.thermal_shutdown ? CFS_CHG_THERMAL : cond.safety_timer_expired ?
        CFS_CHG_TIMER : cond.input_fault ? CFS_CHG_INPUT : CFS_CHG_NORMAL;
    case (ad)
      CFS_ADDR_FAULT: return {cond.watchdog_expired, cond.otg_overload |
        cond.bus_overvoltage | cond.battery_too_low, c,
        cond.battery_overvoltage, cond.temperature_zone_code};
      CFS_ADDR_INPUT: return {cond.input_good_flag, cond.input_voltage_regulating,
        cond.input_current_regulating, 1'b0, cond.topoff_counting_flag,
        cond.adapter_overvoltage, mask};
      CFS_ADDR_PART: return {1'b0, 4'h9, 1'b0, 2'h0};
      default: return 8'h00;
    endcase
  endfunction

  task automatic rd_chk(input logic [7:0] ad);
    cfs_host_inst.access(1'b0, 1'b1, ad, 8'h00);
    check(rdata, model(ad));
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #80000;
    bad_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    cond = '0;
    mask = 2'h0;
    seed = 14;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rd_chk(CFS_ADDR_INPUT);
    rd_chk(CFS_ADDR_PART);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      a = adr[r[1:0]];
      d = r[15:8];
      if (a == CFS_ADDR_PART) d[7] = 1'b0;
      cond = r[31:16];
      cfs_host_inst.access(1'b1, 1'b0, a, d);
      if (a == CFS_ADDR_INPUT) mask = d[1:0];
      repeat (3) @(negedge clk);
      for (int j = 0; j < 4; j++) rd_chk(adr[j]);
      rd_chk(CFS_ADDR_FAULT);
    end
    cfs_host_inst.access(1'b1, 1'b0, CFS_ADDR_INPUT, 8'hff);
    mask = 2'h3;
    rd_chk(CFS_ADDR_INPUT);
    cfs_host_inst.access(1'b1, 1'b0, CFS_ADDR_PART, 8'h80);
    check(rp, 1'b1);
    check(tp, 1'b1);
    @(negedge clk);
    check(rp, 1'b0);
    check(tp, 1'b0);
    mask = 2'h0;
    rd_chk(CFS_ADDR_INPUT);
    rd_chk(CFS_ADDR_PART);
    for (int k = 0; k < 4; k++) begin
      cfs_host_inst.access(1'b1, 1'b0, CFS_ADDR_INPUT, {6'h0, k[1:0]});
      mask = k[1:0];
      cond.input_voltage_regulating = 1'b0;
      cond.input_current_regulating = 1'b0;
      repeat (4) @(negedge clk);
      vcnt = 0;
      ccnt = 0;
      cond.input_voltage_regulating = 1'b1;
      cond.input_current_regulating = 1'b1;
      repeat (8) @(negedge clk);
      check(8'(vcnt), {7'h0, ~k[1]});
      check(8'(ccnt), {7'h0, ~k[0]});
    end
    report_and_stop();
  end
endmodule // tb_top

// ---- src/cfs_pkg.sv ----
// Purpose: Shared constants and types for the charger fault and status registers
// Assumes: Single 250 MHz clock, synchronous active-high reset
// Notes: Offsets are the printed register addresses
//
// Notes on behaviour
// - Watchdog fault bit reads one after watchdog expiry, zero otherwise.
// - Boost fault bit set by OTG overload, bus overvoltage or low battery.
// - Charge fault code: 00 normal, 01 input, 10 thermal, 11 timer.
// - Battery fault bit follows battery overvoltage detection.
// - Temperature zone: 010 warm, 011 cool, 101 cold, 110 hot.
// - Temperature zone tracks live condition; reading never clears it.
// - Input good bit is one while a good source is attached.
// - Voltage regulation status bit follows input voltage regulation activity.
// - Current regulation status bit follows input current regulation activity.
// - Top-off bit is one while the top-off timer counts.
// - Adapter overvoltage bit follows input overvoltage detection.
// - Voltage regulation mask zero passes pulse, one blocks it; resets zero.
// - Current regulation mask zero passes pulse, one blocks it; resets zero.
// - Writing one to reset bit restores defaults and restarts safety timer.
// - Reset bit clears itself once the register reset completes.
package cfs_pkg;

  localparam logic [7:0] CFS_ADDR_FAULT = 8'h09;
  localparam logic [7:0] CFS_ADDR_INPUT = 8'h0a;
  localparam logic [7:0] CFS_ADDR_PART = 8'h0b;

  // Field positions
  localparam int CFS_BIT_WDOG = 7;
  localparam int CFS_BIT_BOOST = 6;
  localparam int CFS_BIT_BATT = 3;
  localparam int CFS_BIT_GOOD = 7;
  localparam int CFS_BIT_VREG = 6;
  localparam int CFS_BIT_CREG = 5;
  localparam int CFS_BIT_TOPOFF = 3;
  localparam int CFS_BIT_ADAPTER_OVERVOLTAGE = 2;
  localparam int CFS_BIT_VMASK = 1;
  localparam int CFS_BIT_CMASK = 0;
  localparam int CFS_BIT_REGRST = 7;

  // Charge fault encodings
  localparam logic [1:0] CFS_CHG_NORMAL = 2'h0;
  localparam logic [1:0] CFS_CHG_INPUT = 2'h1;
  localparam logic [1:0] CFS_CHG_THERMAL = 2'h2;
  localparam logic [1:0] CFS_CHG_TIMER = 2'h3;

  // Temperature zone encodings
  localparam logic [2:0] CFS_ZONE_WARM = 3'h2;
  localparam logic [2:0] CFS_ZONE_COOL = 3'h3;
  localparam logic [2:0] CFS_ZONE_COLD = 3'h5;
  localparam logic [2:0] CFS_ZONE_HOT = 3'h6;

  // Reset values and synchroniser width
  localparam logic CFS_MASK_RST = 1'h0;
  localparam logic [7:0] CFS_RDATA_RST = 8'h00;
  localparam int CFS_SYNC_W = 16;

  // Live conditions from the analog side, asynchronous to clk_i
  typedef struct packed {
    logic watchdog_expired;
    logic otg_overload;
    logic bus_overvoltage;
    logic battery_too_low;
    logic input_fault;
    logic thermal_shutdown;
    logic safety_timer_expired;
    logic battery_overvoltage;
    logic [2:0] temperature_zone_code;
    logic input_good_flag;
    logic input_voltage_regulating;
    logic input_current_regulating;
    logic topoff_counting_flag;
    logic adapter_overvoltage;
  } cfs_cond_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfs_req_t;

  typedef enum logic {
    CFS_ST_IDLE = 1'b0,
    CFS_ST_RESET = 1'b1
  } cfs_state_t;

endpackage

// ---- src/cfs_regs.sv ----
// Purpose: Fault, input status and part information register group
// Assumes: Serial bus slave outside presents one-cycle read and write strobes
// Notes: Read data is registered one cycle after the read strobe
module cfs_regs
  import cfs_pkg::*;
#(
  parameter logic [3:0] PART_ID = 4'h9,   // Arbitrary value
  parameter logic VARIANT_BIT = 1'h0,     // Arbitrary value
  parameter logic [1:0] REVISION = 2'h0   // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire cfs_cond_t cond_i,
  input wire cfs_req_t req_i,
  output logic [7:0] reg_rdata_o,
  output logic voltage_reg_irq_pulse_o,
  output logic current_reg_irq_pulse_o,
  output logic reg_reset_pulse_o,
  output logic safety_timer_restart_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised live conditions

  cfs_cond_t sy;

  cfs_sync #(
    .WIDTH(CFS_SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(cond_i),
    .sync_o(sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read views of each register

  logic [1:0] chg_code;
  logic [7:0] fault_byte;
  logic [7:0] input_byte;
  logic [7:0] part_byte;

  typedef struct packed {
    cfs_state_t state;
    logic vmask;
    logic cmask;
    logic regrst;
    logic vreg_prev;
    logic creg_prev;
    logic [7:0] rdata;
    logic vpulse;
    logic cpulse;
    logic rst_pulse;
    logic timer_pulse;
  } cfs_regs_st_t;

  cfs_regs_st_t st_ff;
  cfs_regs_st_t nxt_st;

  // charge fault encode
  // Thermal shutdown outranks timer, timer outranks input fault
  always_comb begin
    if (sy.thermal_shutdown) begin
      chg_code = CFS_CHG_THERMAL;
    end else if (sy.safety_timer_expired) begin
      chg_code = CFS_CHG_TIMER;
    end else if (sy.input_fault) begin
      chg_code = CFS_CHG_INPUT;
    end else begin
      chg_code = CFS_CHG_NORMAL;
    end
  end

  always_comb begin
    fault_byte = 8'h00;
    fault_byte[CFS_BIT_WDOG] = sy.watchdog_expired;
    fault_byte[CFS_BIT_BOOST] = sy.otg_overload | sy.bus_overvoltage | sy.battery_too_low;
    fault_byte[5:4] = chg_code;
    fault_byte[CFS_BIT_BATT] = sy.battery_overvoltage;
    fault_byte[2:0] = sy.temperature_zone_code;
  end

  always_comb begin
    input_byte = 8'h00;
    input_byte[CFS_BIT_GOOD] = sy.input_good_flag;
    input_byte[CFS_BIT_VREG] = sy.input_voltage_regulating;
    input_byte[CFS_BIT_CREG] = sy.input_current_regulating;
    input_byte[CFS_BIT_TOPOFF] = sy.topoff_counting_flag;
    input_byte[CFS_BIT_ADAPTER_OVERVOLTAGE] = sy.adapter_overvoltage;
    input_byte[CFS_BIT_VMASK] = st_ff.vmask;
    input_byte[CFS_BIT_CMASK] = st_ff.cmask;
  end

  always_comb begin
    part_byte = {st_ff.regrst, PART_ID, VARIANT_BIT, REVISION};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.vreg_prev = sy.input_voltage_regulating;
    nxt_st.creg_prev = sy.input_current_regulating;
    nxt_st.rst_pulse = 1'b0;
    nxt_st.timer_pulse = 1'b0;
    nxt_st.vpulse = sy.input_voltage_regulating & ~st_ff.vreg_prev & ~st_ff.vmask;
    nxt_st.cpulse = sy.input_current_regulating & ~st_ff.creg_prev & ~st_ff.cmask;

    if (req_i.rd) begin
      case (req_i.addr)
        CFS_ADDR_FAULT: begin
          nxt_st.rdata = fault_byte;
        end
        CFS_ADDR_INPUT: begin
          nxt_st.rdata = input_byte;
        end
        CFS_ADDR_PART: begin
          nxt_st.rdata = part_byte;
        end
        default: begin
          nxt_st.rdata = CFS_RDATA_RST;
        end
      endcase
    end

    // only mask and reset bits writable
    if (req_i.wr && req_i.addr == CFS_ADDR_INPUT) begin
      nxt_st.vmask = req_i.wdata[CFS_BIT_VMASK];
      nxt_st.cmask = req_i.wdata[CFS_BIT_CMASK];
    end

    case (st_ff.state)
      CFS_ST_IDLE: begin
        if (req_i.wr && req_i.addr == CFS_ADDR_PART && req_i.wdata[CFS_BIT_REGRST]) begin
          nxt_st.state = CFS_ST_RESET;
          nxt_st.regrst = 1'b1;
          nxt_st.vmask = CFS_MASK_RST;
          nxt_st.cmask = CFS_MASK_RST;
          nxt_st.rst_pulse = 1'b1;
          nxt_st.timer_pulse = 1'b1;
        end
      end
      CFS_ST_RESET: begin
        nxt_st.state = CFS_ST_IDLE;
        nxt_st.regrst = 1'b0;
      end
      default: begin
        nxt_st.state = CFS_ST_IDLE;
        nxt_st.regrst = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign voltage_reg_irq_pulse_o = st_ff.vpulse;
  assign current_reg_irq_pulse_o = st_ff.cpulse;
  assign reg_reset_pulse_o = st_ff.rst_pulse;
  assign safety_timer_restart_o = st_ff.timer_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic rd_fault;
  logic rd_input;
  logic wr_rst;
  assign rd_fault = req_i.rd && req_i.addr == CFS_ADDR_FAULT;
  assign rd_input = req_i.rd && req_i.addr == CFS_ADDR_INPUT;
  assign wr_rst = req_i.wr && req_i.addr == CFS_ADDR_PART && req_i.wdata[CFS_BIT_REGRST]
    && st_ff.state == CFS_ST_IDLE;

  logic rd_part;
  logic rd_unmapped;
  logic wr_mask;
  assign rd_part = req_i.rd && req_i.addr == CFS_ADDR_PART;
  assign rd_unmapped = req_i.rd && req_i.addr != CFS_ADDR_FAULT
    && req_i.addr != CFS_ADDR_INPUT && req_i.addr != CFS_ADDR_PART;
  assign wr_mask = req_i.wr && req_i.addr == CFS_ADDR_INPUT;

  sequence s_rst_cmd;
    wr_rst;
  endsequence

  sequence s_rst_done;
    reg_reset_pulse_o && safety_timer_restart_o && !st_ff.vmask && !st_ff.cmask
      ##1 !st_ff.regrst && !reg_reset_pulse_o;
  endsequence

  // Bit stands for exactly one cycle
  sequence s_bit_clear;
    st_ff.regrst ##1 !st_ff.regrst;
  endsequence

  property p_wdog;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_fault |=> reg_rdata_o[CFS_BIT_WDOG] == $past(sy.watchdog_expired);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog bit wrong");

  property p_boost;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_fault && (sy.otg_overload || sy.bus_overvoltage || sy.battery_too_low)
        |=> reg_rdata_o[CFS_BIT_BOOST];
  endproperty
  a_boost: assert property (p_boost) else $error("boost bit not set");

  property p_chg;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_fault && sy.thermal_shutdown |=> reg_rdata_o[5:4] == CFS_CHG_THERMAL;
  endproperty
  a_chg: assert property (p_chg) else $error("charge code wrong");

  property p_batt;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_fault |=> reg_rdata_o[CFS_BIT_BATT] == $past(sy.battery_overvoltage);
  endproperty
  a_batt: assert property (p_batt) else $error("battery bit wrong");

  property p_zone;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_fault |=> reg_rdata_o[2:0] == $past(sy.temperature_zone_code);
  endproperty
  a_zone: assert property (p_zone) else $error("zone not live");

  property p_input;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_input |=> reg_rdata_o[7:5] == $past({sy.input_good_flag,
        sy.input_voltage_regulating, sy.input_current_regulating})
        && reg_rdata_o[CFS_BIT_TOPOFF] == $past(sy.topoff_counting_flag)
        && reg_rdata_o[CFS_BIT_ADAPTER_OVERVOLTAGE] == $past(sy.adapter_overvoltage);
  endproperty
  a_input: assert property (p_input) else $error("input status wrong");

  property p_vpulse;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(sy.input_voltage_regulating) && !st_ff.vmask |=> voltage_reg_irq_pulse_o;
  endproperty
  a_vpulse: assert property (p_vpulse) else $error("voltage pulse lost");

  property p_cmask;
    @(posedge clk_i) disable iff (sys_rst_i)
      st_ff.cmask |=> !current_reg_irq_pulse_o;
  endproperty
  a_cmask: assert property (p_cmask) else $error("masked pulse seen");

  property p_rst;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_rst_cmd |=> s_rst_done;
  endproperty
  a_rst: assert property (p_rst) else $error("register reset wrong");

  property p_ro;
    @(posedge clk_i) disable iff (sys_rst_i)
      req_i.wr && req_i.addr != CFS_ADDR_INPUT && !wr_rst
        |=> $stable(st_ff.vmask) && $stable(st_ff.cmask);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write took effect");

  property p_part;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_part |=> reg_rdata_o[6:0] == {PART_ID, VARIANT_BIT, REVISION};
  endproperty
  a_part: assert property (p_part) else $error("identity field wrong");

  property p_unmapped;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_unmapped |=> reg_rdata_o == CFS_RDATA_RST;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_bit_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_rst_cmd |=> s_bit_clear;
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("reset bit not self clearing");

  property p_mask_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_mask |=> st_ff.vmask == $past(req_i.wdata[CFS_BIT_VMASK])
        && st_ff.cmask == $past(req_i.wdata[CFS_BIT_CMASK]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_vmask;
    @(posedge clk_i) disable iff (sys_rst_i)
      st_ff.vmask |=> !voltage_reg_irq_pulse_o;
  endproperty
  a_vmask: assert property (p_vmask) else $error("masked voltage pulse seen");

  property p_vlen;
    @(posedge clk_i) disable iff (sys_rst_i)
      voltage_reg_irq_pulse_o |=> !voltage_reg_irq_pulse_o;
  endproperty
  a_vlen: assert property (p_vlen) else $error("voltage pulse too long");

  property p_cpulse;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(sy.input_current_regulating) && !st_ff.cmask |=> current_reg_irq_pulse_o;
  endproperty
  a_cpulse: assert property (p_cpulse) else $error("current pulse lost");

  property p_timer;
    @(posedge clk_i) disable iff (sys_rst_i)
      reg_reset_pulse_o |-> safety_timer_restart_o;
  endproperty
  a_timer: assert property (p_timer) else $error("safety timer not restarted");

endmodule // cfs_regs

// ---- src/cfs_sync.sv ----
// Purpose: Two-stage synchroniser for a vector of asynchronous levels
// Assumes: Each bit is an independent slow level
// Notes: Bits are not coherent with each other across a change
module cfs_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= async_i[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign sync_o = sync_ff;

endmodule // cfs_sync
